/* verilog/smbus_status_event_flags.sv */
// Host and target status flags of the system management bus controller
`default_nettype none
module smbus_status_event_flags (
	// Controller clock and reset
	input  wire logic                                  mclk,
	input  wire logic                                  reset,
	// I/O register port
	input  wire logic [smbus_status_pkg::IO_ADDR_W-1:0] io_base,
	input  wire logic [smbus_status_pkg::IO_ADDR_W-1:0] io_addr,
	input  wire logic                                  io_wr,
	input  wire logic                                  io_rd,
	input  wire logic [smbus_status_pkg::BYTE_W-1:0]    io_wdata,
	output var  logic [smbus_status_pkg::BYTE_W-1:0]    io_rdata,
	// Host engine status
	input  wire logic                                  host_busy,
	input  wire logic                                  host_done,
	input  wire logic                                  host_collision,
	input  wire logic                                  host_bad_command,
	input  wire logic                                  host_unclaimed,
	input  wire logic                                  host_timeout,
	input  wire logic                                  abort_command_bit,
	input  wire logic                                  host_irq_enable,
	output var  logic                                  host_stop,
	// Target side controls
	input  wire logic                                  pin_alert_gate,
	input  wire logic                                  target_port_gate,
	input  wire logic                                  mirror_one_gate,
	input  wire logic                                  mirror_two_gate,
	input  wire logic [smbus_status_pkg::BUS_ADDR_W-1:0] mirror_port_one_address,
	input  wire logic [smbus_status_pkg::BUS_ADDR_W-1:0] mirror_port_two_address,
	input  wire logic [smbus_status_pkg::BYTE_W-1:0]    target_command_match,
	input  wire logic [smbus_status_pkg::DATA_EV_W-1:0] target_event_mask,
	// Alert pin, asynchronous
	input  wire logic                                  bus_alert_input_n,
	// Link side, on the bus clock
	input  wire logic                                  link_clk,
	input  wire logic                                  link_frame_done,
	input  wire logic [smbus_status_pkg::BUS_ADDR_W-1:0] link_addr,
	input  wire logic [smbus_status_pkg::BYTE_W-1:0]    link_cmd,
	input  wire logic [smbus_status_pkg::DATA_EV_W-1:0] link_data,
	// Combined interrupt or resume request
	output var  logic                                  event_request
);
	import smbus_status_pkg::*;

	logic [BYTE_W-1:0]     host_status;
	logic [BYTE_W-1:0]     target_status;
	logic                  link_rst;
	logic                  frame_toggle;
	logic [BUS_ADDR_W-1:0] hold_addr;
	logic [BYTE_W-1:0]     hold_cmd;
	logic [DATA_EV_W-1:0]  hold_data;
	logic                  toggle_sync;
	logic                  toggle_seen;
	logic                  new_frame;
	logic                  alert_sync_n;
	logic                  alert_prev_n;
	logic                  alert_fall;
	logic                  sel;
	logic [OFS_W-1:0]      ofs;
	logic                  wr_host;
	logic                  wr_target;
	logic                  rd_hit;
	logic                  set_aborted;
	logic                  set_coll;
	logic                  set_error;
	logic                  set_done;
	logic                  set_alert;
	logic                  set_mirror1;
	logic                  set_mirror2;
	logic                  set_event;
	logic                  any_enabled;
	logic [IO_ADDR_W-1:0]  rel_addr;

	// Link reset follows the controller reset into the bus clock domain
	sync_2ff #(.WIDTH(1), .INIT(1'b1)) u_link_rst (
		.clk  (link_clk),
		.rst  (1'b0),
		.din  (reset),
		.dout (link_rst)
	);

	// Capture frame fields on the bus clock; the toggle announces them.
	// Fields stay stable until the next frame, far longer than the crossing.
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			frame_toggle <= 1'b0;
			hold_addr    <= '0;
			hold_cmd     <= '0;
			hold_data    <= '0;
		end else if (link_frame_done) begin
			frame_toggle <= ~frame_toggle;
			hold_addr    <= link_addr;
			hold_cmd     <= link_cmd;
			hold_data    <= link_data;
		end
	end

	// Frame toggle crosses into the controller domain
	sync_2ff #(.WIDTH(1), .INIT(1'b0)) u_toggle (
		.clk  (mclk),
		.rst  (reset),
		.din  (frame_toggle),
		.dout (toggle_sync)
	);

	// Alert pin is asynchronous; idle level is high
	sync_2ff #(.WIDTH(1), .INIT(1'b1)) u_alert (
		.clk  (mclk),
		.rst  (reset),
		.din  (bus_alert_input_n),
		.dout (alert_sync_n)
	);

	// Edge detectors on the synchronised levels
	always_ff @(posedge mclk) begin
		if (reset) begin
			toggle_seen  <= 1'b0;
			alert_prev_n <= 1'b1;
		end else begin
			toggle_seen  <= toggle_sync;
			alert_prev_n <= alert_sync_n;
		end
	end

	assign new_frame  = toggle_sync ^ toggle_seen;
	assign alert_fall = alert_prev_n & ~alert_sync_n;

	// Register decode relative to the programmed window base
	assign rel_addr  = io_addr - io_base;
	assign sel       = (rel_addr[IO_ADDR_W-1:OFS_W] == '0);
	assign ofs       = rel_addr[OFS_W-1:0];
	assign wr_host   = io_wr && sel && (ofs == OFS_HOST_STATUS);
	assign wr_target = io_wr && sel && (ofs == OFS_TARGET_STATUS);
	assign rd_hit    = io_rd && sel;

	// Hardware set conditions
	assign set_aborted = abort_command_bit;
	assign set_coll    = host_collision;
	assign set_error   = host_bad_command | host_unclaimed
		| host_timeout;
	assign set_done    = host_done;
	assign set_alert   = alert_fall && pin_alert_gate;
	assign set_mirror2 = new_frame
		&& (hold_addr == mirror_port_two_address);
	assign set_mirror1 = new_frame
		&& (hold_addr == mirror_port_one_address);
	assign set_event   = new_frame && target_port_gate
		&& (hold_addr == OWN_TGT_ADDR)
		&& (hold_cmd == target_command_match)
		&& ((hold_data & target_event_mask) != '0);

	// Host status: write one clears the event flags, a set in the same cycle wins; the active bit mirrors host_busy
	always_ff @(posedge mclk) begin
		if (reset) begin
			host_status <= STATUS_RESET;
		end else begin
			host_status[HS_ABORTED] <= set_aborted | (host_status[HS_ABORTED]
				& ~(wr_host & io_wdata[HS_ABORTED]));
			host_status[HS_COLL]    <= set_coll | (host_status[HS_COLL]
				& ~(wr_host & io_wdata[HS_COLL]));
			host_status[HS_ERROR]   <= set_error | (host_status[HS_ERROR]
				& ~(wr_host & io_wdata[HS_ERROR]));
			host_status[HS_DONE]    <= set_done | (host_status[HS_DONE]
				& ~(wr_host & io_wdata[HS_DONE]));
			host_status[HS_ACTIVE]  <= host_busy;
			host_status[BYTE_W-1:HS_ABORTED+1] <= '0;
		end
	end

	// Target status: write one clears, a set in the same cycle wins
	always_ff @(posedge mclk) begin
		if (reset) begin
			target_status <= STATUS_RESET;
		end else begin
			target_status[TS_ALERT]   <= set_alert | (target_status[TS_ALERT]
				& ~(wr_target & io_wdata[TS_ALERT]));
			target_status[TS_MIRROR2] <= set_mirror2
				| (target_status[TS_MIRROR2]
				& ~(wr_target & io_wdata[TS_MIRROR2]));
			target_status[TS_MIRROR1] <= set_mirror1
				| (target_status[TS_MIRROR1]
				& ~(wr_target & io_wdata[TS_MIRROR1]));
			target_status[TS_EVENT]   <= set_event | (target_status[TS_EVENT]
				& ~(wr_target & io_wdata[TS_EVENT]));
			target_status[BYTE_W-1:TS_ALERT+1] <= '0;
			target_status[TS_EVENT-1:0]        <= '0;
		end
	end

	// Read data; other offsets in the window belong elsewhere, read zero
	always_ff @(posedge mclk) begin
		if (reset) begin
			io_rdata <= '0;
		end else if (rd_hit) begin
			case (ofs)
				OFS_HOST_STATUS:   io_rdata <= host_status;
				OFS_TARGET_STATUS: io_rdata <= target_status;
				default:           io_rdata <= '0;
			endcase
		end
	end

	// Stop pulse to the host engine, one cycle after the abort write
	always_ff @(posedge mclk) begin
		if (reset) begin
			host_stop <= 1'b0;
		end else begin
			host_stop <= abort_command_bit;
		end
	end

	// Completion only requests when the host interrupt is enabled;
	// error flags always request since they end the transaction
	assign any_enabled = host_status[HS_ABORTED] | host_status[HS_COLL]
		| host_status[HS_ERROR]
		| (host_status[HS_DONE] & host_irq_enable)
		| (target_status[TS_ALERT] & pin_alert_gate)
		| (target_status[TS_MIRROR2] & mirror_two_gate)
		| (target_status[TS_MIRROR1] & mirror_one_gate)
		| (target_status[TS_EVENT] & target_port_gate);

	// Registered request, so the output is glitch free
	always_ff @(posedge mclk) begin
		if (reset) begin
			event_request <= 1'b0;
		end else begin
			event_request <= any_enabled;
		end
	end

	// Checks on the controller clock
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_abort_write;
		abort_command_bit ##0 !wr_host;
	endsequence

	property p_abort_sets;
		s_abort_write |=> host_status[HS_ABORTED] && host_stop
			##1 event_request;
	endproperty
	a_abort_sets: assert property (p_abort_sets)
		else $error("abort did not set flag, stop and request");

	property p_coll_sets;
		host_collision |=> host_status[HS_COLL];
	endproperty
	a_coll_sets: assert property (p_coll_sets)
		else $error("collision flag not set");

	property p_error_sets;
		(host_bad_command || host_unclaimed || host_timeout)
			|=> host_status[HS_ERROR];
	endproperty
	a_error_sets: assert property (p_error_sets)
		else $error("transaction error flag not set");

	property p_done_held;
		host_done |=> host_status[HS_DONE] [*3] or
			(host_status[HS_DONE] ##[0:2] $past(wr_host));
	endproperty
	a_done_held: assert property (p_done_held)
		else $error("done flag not set or dropped without a write");

	// Busy is mirrored one cycle late, so the read must follow a busy cycle
	sequence s_busy_then_read;
		host_busy ##1 (rd_hit && ofs == OFS_HOST_STATUS);
	endsequence

	property p_busy_read;
		s_busy_then_read |=> io_rdata[HS_ACTIVE];
	endproperty
	a_busy_read: assert property (p_busy_read)
		else $error("busy bit did not read one");

	property p_w1c;
		wr_target && io_wdata[TS_ALERT] && !set_alert
			|=> !target_status[TS_ALERT];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear alert flag");

	property p_zero_keeps;
		host_status[HS_DONE] && wr_host && !io_wdata[HS_DONE]
			|=> host_status[HS_DONE];
	endproperty
	a_zero_keeps: assert property (p_zero_keeps)
		else $error("write zero changed a flag");

	sequence s_alert_drop;
		alert_sync_n ##1 !alert_sync_n;
	endsequence

	property p_alert_gate;
		s_alert_drop ##0 !pin_alert_gate ##0 !target_status[TS_ALERT]
			|=> !target_status[TS_ALERT];
	endproperty
	a_alert_gate: assert property (p_alert_gate)
		else $error("alert flag set while gate off");

	property p_alert_sets;
		s_alert_drop ##0 pin_alert_gate |=> target_status[TS_ALERT];
	endproperty
	a_alert_sets: assert property (p_alert_sets)
		else $error("alert flag not set while gate on");

	property p_event_own_port;
		new_frame && hold_addr != OWN_TGT_ADDR && !target_status[TS_EVENT]
			|=> !target_status[TS_EVENT];
	endproperty
	a_event_own_port: assert property (p_event_own_port)
		else $error("event flag set for foreign address");

	property p_mirror2_sets;
		new_frame && hold_addr == mirror_port_two_address
			|=> target_status[TS_MIRROR2];
	endproperty
	a_mirror2_sets: assert property (p_mirror2_sets)
		else $error("second mirror flag not set on address match");

	property p_mirror1_sets;
		new_frame && hold_addr == mirror_port_one_address
			|=> target_status[TS_MIRROR1];
	endproperty
	a_mirror1_sets: assert property (p_mirror1_sets)
		else $error("first mirror flag not set on address match");

	property p_event_sets;
		new_frame && target_port_gate && hold_addr == OWN_TGT_ADDR
			&& hold_cmd == target_command_match
			&& (hold_data & target_event_mask) != '0
			|=> target_status[TS_EVENT];
	endproperty
	a_event_sets: assert property (p_event_sets)
		else $error("target event flag not set on a full match");

	property p_request_follows;
		any_enabled [*2] |=> event_request;
	endproperty
	a_request_follows: assert property (p_request_follows)
		else $error("request not raised for a set flag");

	property p_reserved_zero;
		rd_hit |=> io_rdata[BYTE_W-1:TS_ALERT+1] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

/* verilog/smbus_status_pkg.sv */
// Constants shared by the status flag block
`default_nettype none
package smbus_status_pkg;
	// Register offsets inside the I/O window
	localparam logic [3:0] OFS_HOST_STATUS   = 4'h0;
	localparam logic [3:0] OFS_TARGET_STATUS = 4'h1;
	localparam int         OFS_W             = 4;
	localparam int         IO_ADDR_W         = 16;
	localparam int         BYTE_W            = 8;
	localparam int         DATA_EV_W         = 16;
	localparam int         BUS_ADDR_W        = 7;
	// Host status bit positions
	localparam int HS_ACTIVE  = 0;
	localparam int HS_DONE    = 1;
	localparam int HS_ERROR   = 2;
	localparam int HS_COLL    = 3;
	localparam int HS_ABORTED = 4;
	// Target status bit positions
	localparam int TS_EVENT   = 2;
	localparam int TS_MIRROR1 = 3;
	localparam int TS_MIRROR2 = 4;
	localparam int TS_ALERT   = 5;
	// Reset values and fixed target port address
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [6:0] OWN_TGT_ADDR  = 7'h10;
	localparam int         SYNC_STAGES   = 2;
endpackage
`default_nettype wire

/* verilog/sync_2ff.sv */
// Two flip-flop synchroniser for levels entering a clock domain
`default_nettype none
module sync_2ff #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Destination clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Asynchronous level in, synchronised level out
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	// First stage is read only by the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= INIT;
			dout <= INIT;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule
`default_nettype wire

/* verif/smbus_far_model.sv */
// Far-side model: external bus master frames and the alert pin
`default_nettype none
module smbus_far_model (
	// Link clock and frame fields
	output var logic        link_clk,
	output var logic        link_frame_done,
	output var logic [6:0]  link_addr,
	output var logic [7:0]  link_cmd,
	output var logic [15:0] link_data,
	// Alert pin, pulled up when released
	output var logic        bus_alert_input_n
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus: clock parked low, pin released to its pull-up
	initial begin
		link_clk = 1'b0;
		link_frame_done = 1'b0;
		{link_addr, link_cmd, link_data} = '0;
		bus_alert_input_n = 1'b1;
	end

	// Clock runs only inside frames or while reset is applied
	task automatic tick(input int n);
		repeat (n) begin
			#3 link_clk = 1'b1;
			#3 link_clk = 1'b0;
		end
	endtask

	// Fields ride one done edge and stay put until the next frame
	task automatic frame(input logic [30:0] f);
		tick(3);
		{link_addr, link_cmd, link_data} = f;
		link_frame_done = 1'b1;
		tick(1);
		link_frame_done = 1'b0;
		tick(2);
	endtask

	// Pin held low long enough for the slow synchroniser to see it
	task automatic alert();
		bus_alert_input_n = 1'b0;
		#200 bus_alert_input_n = 1'b1;
	endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the status flag block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import smbus_status_pkg::*;

	// Stimulus
	logic        mclk, reset, io_wr, io_rd, host_busy, host_irq_enable;
	logic        pin_alert_gate, target_port_gate;
	logic        mirror_one_gate, mirror_two_gate;
	logic [15:0] io_base, io_addr, target_event_mask;
	logic [7:0]  io_wdata, target_command_match;
	logic [6:0]  mirror_port_one_address, mirror_port_two_address;
	logic [5:0]  hev;
	wire  logic  host_done         = hev[0];
	wire  logic  host_collision    = hev[1];
	wire  logic  host_bad_command  = hev[2];
	wire  logic  host_unclaimed    = hev[3];
	wire  logic  host_timeout      = hev[4];
	wire  logic  abort_command_bit = hev[5];
	// Observed and far-side nets
	wire  logic [7:0]  io_rdata, link_cmd;
	wire  logic [6:0]  link_addr;
	wire  logic [15:0] link_data;
	wire  logic  host_stop, event_request, link_clk, link_frame_done;
	wire  logic  bus_alert_input_n;
	int          n_mismatch   = 0;
	int          total_checks = 0;
	// Expected host status per pulse line, in hev order
	logic [7:0]  hrow [6] = '{8'h02, 8'h08, 8'h04, 8'h04, 8'h04, 8'h10};
	// Frame fields beside the target status they should leave
	logic [38:0] trow [6] = '{
		{7'h2A, 8'h00, 16'h0000, 8'h08},
		{7'h33, 8'h00, 16'h0000, 8'h10},
		{7'h10, 8'h5C, 16'h0100, 8'h04},
		{7'h10, 8'h5D, 16'h0100, 8'h00},
		{7'h10, 8'h5C, 16'h00FF, 8'h00},
		{7'h11, 8'h5C, 16'h0100, 8'h00}};

	smbus_status_event_flags u_smbus_status_event_flags (
		.mclk(mclk), .reset(reset), .io_base(io_base),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata),
		.host_busy(host_busy), .host_done(host_done),
		.host_collision(host_collision),
		.host_bad_command(host_bad_command),
		.host_unclaimed(host_unclaimed), .host_timeout(host_timeout),
		.abort_command_bit(abort_command_bit),
		.host_irq_enable(host_irq_enable), .host_stop(host_stop),
		.pin_alert_gate(pin_alert_gate),
		.target_port_gate(target_port_gate),
		.mirror_one_gate(mirror_one_gate),
		.mirror_two_gate(mirror_two_gate),
		.mirror_port_one_address(mirror_port_one_address),
		.mirror_port_two_address(mirror_port_two_address),
		.target_command_match(target_command_match),
		.target_event_mask(target_event_mask),
		.bus_alert_input_n(bus_alert_input_n),
		.link_clk(link_clk), .link_frame_done(link_frame_done),
		.link_addr(link_addr), .link_cmd(link_cmd),
		.link_data(link_data), .event_request(event_request)
	);
	smbus_far_model u_smbus_far_model (
		.link_clk(link_clk), .link_frame_done(link_frame_done),
		.link_addr(link_addr), .link_cmd(link_cmd),
		.link_data(link_data), .bus_alert_input_n(bus_alert_input_n)
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Every drive lands 1 ns after an edge, away from sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Strobes drop for a cycle so back-to-back calls never collide
	task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
		io_addr = io_base + ofs;
		io_wdata = d;
		io_wr = 1'b1;
		cyc(1);
		io_wr = 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [15:0] ofs, input logic [7:0] e);
		io_addr = io_base + ofs;
		io_rd = 1'b1;
		cyc(1);
		io_rd = 1'b0;
		chk(io_rdata, e);
		cyc(1);
	endtask

	task automatic pulse(input int i);
		hev[i] = 1'b1;
		cyc(1);
		hev[i] = 1'b0;
	endtask

	// Link clock must tick during reset to clear the bus side
	task automatic do_reset();
		reset = 1'b1;
		u_smbus_far_model.tick(6);
		cyc(3);
		reset = 1'b0;
		cyc(1);
	endtask

	task automatic tally_and_finish();
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Generous bound: the sequence needs well under 20 us
	initial begin
		#100us;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		{io_wr, io_rd, host_busy, hev, io_addr, io_wdata} = '0;
		io_base = 16'h0500;
		{host_irq_enable, pin_alert_gate, target_port_gate} = 3'b111;
		{mirror_one_gate, mirror_two_gate} = 2'b11;
		mirror_port_one_address = 7'h2A;
		mirror_port_two_address = 7'h33;
		target_command_match = 8'h5C;
		target_event_mask = 16'h0F00;
		do_reset();
		rd(0, 8'h00);
		rd(1, 8'h00);
		// Host event lines, one per row
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			if (i == 5) chk(8'(host_stop), 8'h01);
			cyc(2);
			chk(8'(host_stop), 8'h00);
			chk(8'(event_request), 8'h01);
			rd(0, hrow[i]);
			wr(0, hrow[i]);
			cyc(2);
			chk(8'(event_request), 8'h00);
			rd(0, 8'h00);
		end
		// Link frames, one per row
		for (int i = 0; i < 6; i++) begin
			u_smbus_far_model.frame(trow[i][38:8]);
			cyc(10);
			rd(1, trow[i][7:0]);
			chk(8'(event_request), 8'(trow[i][7:0] != 0));
			wr(1, 8'hFF);
			cyc(2);
		end
		// Busy mirror; nothing else is touched while it reads one
		host_busy = 1'b1;
		cyc(2);
		rd(0, 8'h01);
		chk(8'(event_request), 8'h00);
		host_busy = 1'b0;
		cyc(2);
		rd(0, 8'h00);
		// Zero writes, unmapped offset and out-of-window write keep flag
		pulse(0);
		wr(0, 8'hFD);
		wr(2, 8'hFF);
		wr(16, 8'h02);
		rd(0, 8'h02);
		rd(2, 8'h00);
		// A new event in the clearing cycle must survive
		io_addr = io_base;
		io_wdata = 8'h02;
		{io_wr, hev[0]} = 2'b11;
		cyc(1);
		{io_wr, hev[0]} = 2'b00;
		cyc(1);
		rd(0, 8'h02);
		wr(0, 8'h02);
		// Completion without its enable sets the flag but no request
		host_irq_enable = 1'b0;
		pulse(0);
		cyc(3);
		chk(8'(event_request), 8'h00);
		rd(0, 8'h02);
		wr(0, 8'h02);
		host_irq_enable = 1'b1;
		// Alert pin gated off, then on
		pin_alert_gate = 1'b0;
		u_smbus_far_model.alert();
		cyc(8);
		rd(1, 8'h00);
		chk(8'(event_request), 8'h00);
		pin_alert_gate = 1'b1;
		u_smbus_far_model.alert();
		cyc(8);
		rd(1, 8'h20);
		chk(8'(event_request), 8'h01);
		wr(1, 8'h20);
		// Mirror gate off keeps the flag but not the request
		{mirror_one_gate, target_port_gate} = 2'b00;
		u_smbus_far_model.frame({7'h2A, 8'h00, 16'h0000});
		cyc(10);
		chk(8'(event_request), 8'h00);
		u_smbus_far_model.frame({7'h10, 8'h5C, 16'h0100});
		cyc(10);
		rd(1, 8'h08);
		wr(1, 8'hFF);
		// Reset in mid-run clears a pending flag
		pulse(1);
		do_reset();
		rd(0, 8'h00);
		chk(8'(event_request), 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
